// [rtl/ahs_pkg.sv]
package ahs_pkg;
  // Host-side register selects
  localparam logic [2:0] ADDR_STATUS_CMD = 3'h7; // Primary block: status read, command write
  localparam logic [2:0] ADDR_ALT_FDC = 3'h6;    // Alternate block: mirror read, control write
  localparam logic [2:0] ADDR_DIN = 3'h7;        // Alternate block: cable loopback read
  // Status bit positions
  localparam int ST_BUSY = 7;
  localparam int ST_READY = 6;
  localparam int ST_FAULT = 5;
  localparam int ST_SEEK = 4;
  localparam int ST_TRANSFER_REQUEST_FLAG = 3;
  localparam int ST_CORR = 2;
  localparam int ST_INDEX = 1;
  localparam int ST_ERR = 0;
  // Fixed-disk control bits
  localparam int FDC_HD3 = 3;
  localparam int FDC_RESET = 2;
  localparam int FDC_HOST_IRQ_ENABLE_N_N = 1;
  localparam int FDC_DMA = 0;
  localparam int FDC_W = 4;
  localparam logic [3:0] FDC_RST_VAL = 4'h0;
  // Cable loopback layout
  localparam int DIN_WRITE_GATE_N = 6;
  localparam int DIN_W = 7;
  localparam logic [5:0] DIN_RST_VAL = 6'h3f;    // Active-low lines at rest
  localparam logic [7:0] DIN_OE = 8'h7f;         // Top bit left undriven
  localparam logic [7:0] OE_ALL = 8'hff;
  localparam logic [7:0] OE_NONE = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // Controller sequencing
  typedef enum logic [1:0] {
    DEV_IDLE = 2'b00,
    DEV_EXEC = 2'b01,
    DEV_XFER = 2'b10,
    DEV_RESET = 2'b11
  } ahs_dev_state_t;
  typedef enum logic {
    HST_IDLE = 1'b0,
    HST_WAIT = 1'b1
  } ahs_hst_state_t;
  // Host end software registers (byte addresses)
  localparam logic [3:0] OFS_ACCESS = 4'h0;
  localparam logic [3:0] OFS_RESULT = 4'h4;
  localparam logic [3:0] OFS_PINCTL = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Field positions in the access register
  localparam int ACC_ADDR_LSB = 0;
  localparam int ACC_ALT = 3;
  localparam int ACC_WRITE = 4;
  localparam int ACC_DATA_LSB = 8;
  // Field positions in the result register
  localparam int RES_OE_LSB = 8;
  localparam int RES_PEND = 16;
  localparam int RES_REFUSED = 17;
  localparam int RES_IRQ = 18;
  localparam int RES_DMA = 19;
  localparam int RES_BUSY = 20;
  localparam int RES_TRANSFER_REQUEST_FLAG = 21;
endpackage

// [rtl/ahs_link_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface ahs_link_if;
  logic host_reset;     // Host reset pin, active high
  logic rd;             // One-cycle read strobe
  logic wr;             // One-cycle write strobe
  logic alt_sel;        // Selects the alternate register block
  logic [2:0] addr;     // Register select
  logic [7:0] wdata;    // Write byte
  logic [7:0] rdata;    // Read byte
  logic [7:0] rdata_oe; // Per-bit drive of the read byte
  logic rvalid;         // Read byte valid, one cycle
  logic irq;            // Host interrupt request
  logic dma_gate;       // Host DMA channel gate
  modport dev (
    input host_reset, rd, wr, alt_sel, addr, wdata,
    output rdata, rdata_oe, rvalid, irq, dma_gate
  );
  modport host (
    output host_reset, rd, wr, alt_sel, addr, wdata,
    input rdata, rdata_oe, rvalid, irq, dma_gate
  );
endinterface
`default_nettype wire

// [rtl/ahs_device_end.sv]
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// How it works
// - Busy set: other status bits read zero
// - Primary status read clears pending interrupt
// - Error bit set on failure, cleared by command
// - Index bit follows drive, gated by ready
// - Corrected bit set on ECC fix, command clears
// - Transfer request bit marks buffer transfer
// - Transfer request allows any register access
// - Seek bit follows drive seek complete
// - Fault bit follows drive write fault
// - Ready bit follows drive ready
// - Host touches only primary status and alternate regs while busy
// - Busy set by resets, soft reset, command
// - Host waits idle or mid-transfer before writing command
// - Command during transfer aborts and restarts
// - Alternate status mirrors, never clears interrupt
// - Control: head3, reset, irq enable_n, dma
// - DMA gate needs mode and control enable
// - Control register cleared by any of the three resets
// - Loopback register shows active-low cable lines
// - Loopback read drives bits six to zero
// - Write-gate bit never reset, others reset
// - Drive/head reset by resets, soft, diagnostic
// - Failure loads error code with error bit
module ahs_device_end #(
  parameter logic [7:0] DIAG_CMD = 8'h90 // Diagnostic command code
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  ahs_link_if.dev link,
  input wire logic i_local_reset_pin,
  input wire logic i_drive_ready,
  input wire logic i_drive_index,
  input wire logic i_seek_done_flag,
  input wire logic i_drive_write_fault,
  input wire logic i_write_gate_n,
  input wire logic i_head3_or_reduced_current_n,
  input wire logic i_head_sel2_n,
  input wire logic i_head_sel1_n,
  input wire logic i_head_sel0_n,
  input wire logic i_drive_sel1_n,
  input wire logic i_drive_sel0_n,
  input wire logic i_cmd_done,
  input wire logic i_cmd_error,
  input wire logic [7:0] i_error_code,
  input wire logic i_corrected_flag,
  input wire logic i_xfer_start,
  input wire logic i_xfer_end,
  input wire logic i_dma_mode,
  input wire logic i_dma_ctl_enable,
  output logic o_cmd_strobe,
  output logic [7:0] o_cmd_code,
  output logic o_abort_xfer,
  output logic o_drive_head_reset,
  output logic [7:0] o_error_code,
  output logic o_head3_select_enable,
  output logic o_busy
);

  ////////////////////////////////////////////////////////////////////////////////
  // State record
  typedef struct packed {
    ahs_pkg::ahs_dev_state_t state;  // Controller sequencing
    logic [3:0] fdc;                 // Fixed-disk control
    logic err;                       // Error flag
    logic corr;                      // Corrected-data flag
    logic irq;                       // Pending host interrupt
    logic [7:0] err_code;            // Error code
    logic [7:0] cmd;                 // Last command code
    logic cmd_stb;                   // Command start pulse
    logic abort_stb;                 // Transfer abort pulse
    logic dh_rst;                    // Drive/head reset pulse
    logic [6:0] cab_s1;              // Cable sync stage one
    logic [6:0] cab_s2;              // Cable sync stage two
    logic [3:0] drv_s1;              // Drive sync stage one
    logic [3:0] drv_s2;              // Drive sync stage two
    logic lrst_s1;                   // Local reset sync stage one
    logic lrst_s2;                   // Local reset sync stage two
    logic [6:0] din;                 // Cable loopback
    logic [7:0] rdata;               // Read byte
    logic [7:0] rdata_oe;            // Read byte drive
    logic rvalid;                    // Read answer pulse
    logic dma_gate;                  // Host DMA gate
    logic busy;                      // Busy, registered for the pin
  } ahs_dev_st_t;

  ahs_dev_st_t s_reg;
  ahs_dev_st_t s_next;

  ////////////////////////////////////////////////////////////////////////////////
  // Status byte from the current state
  function automatic logic [7:0] status_byte(input ahs_dev_st_t st);
    logic [7:0] b;
    logic busy;
    b = ahs_pkg::BYTE_ZERO;
    busy = (st.state == ahs_pkg::DEV_EXEC) || (st.state == ahs_pkg::DEV_RESET);
    b[ahs_pkg::ST_BUSY] = busy;
    if (!busy) begin
      b[ahs_pkg::ST_READY] = st.drv_s2[3];
      b[ahs_pkg::ST_INDEX] = st.drv_s2[3] & st.drv_s2[2];
      b[ahs_pkg::ST_SEEK] = st.drv_s2[1];
      b[ahs_pkg::ST_FAULT] = st.drv_s2[0];
      b[ahs_pkg::ST_TRANSFER_REQUEST_FLAG] = (st.state == ahs_pkg::DEV_XFER);
      b[ahs_pkg::ST_CORR] = st.corr;
      b[ahs_pkg::ST_ERR] = st.err;
    end
    // Other bits held at zero while busy
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic any_rst;
    logic can_cmd;
    any_rst = 1'b0;
    can_cmd = 1'b0;
    s_next = s_reg;
    s_next.cmd_stb = 1'b0;
    s_next.abort_stb = 1'b0;
    s_next.dh_rst = 1'b0;
    s_next.rvalid = 1'b0;
    // Synchronisers for pins
    s_next.cab_s1 = {i_write_gate_n, i_head3_or_reduced_current_n, i_head_sel2_n,
                     i_head_sel1_n, i_head_sel0_n, i_drive_sel1_n, i_drive_sel0_n};
    s_next.cab_s2 = s_reg.cab_s1;
    s_next.drv_s1 = {i_drive_ready, i_drive_index, i_seek_done_flag, i_drive_write_fault};
    s_next.drv_s2 = s_reg.drv_s1;
    s_next.lrst_s1 = i_local_reset_pin;
    s_next.lrst_s2 = s_reg.lrst_s1;
    // Loopback follows the cable
    s_next.din = s_reg.cab_s2;
    any_rst = i_rst | s_reg.lrst_s2 | link.host_reset;
    can_cmd = (s_reg.state == ahs_pkg::DEV_IDLE) || (s_reg.state == ahs_pkg::DEV_XFER);
    // Host reads
    if (link.rd) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = ahs_pkg::BYTE_ZERO;
      s_next.rdata_oe = ahs_pkg::OE_ALL;
      if (!link.alt_sel && link.addr == ahs_pkg::ADDR_STATUS_CMD) begin
        s_next.rdata = status_byte(s_reg);
        s_next.irq = 1'b0;
      end else if (link.alt_sel && link.addr == ahs_pkg::ADDR_ALT_FDC) begin
        s_next.rdata = status_byte(s_reg);
      end else if (link.alt_sel && link.addr == ahs_pkg::ADDR_DIN) begin
        s_next.rdata = {1'b0, s_reg.din};
        s_next.rdata_oe = ahs_pkg::DIN_OE;
      end
    end
    // Host writes
    if (link.wr) begin
      if (link.alt_sel && link.addr == ahs_pkg::ADDR_ALT_FDC) begin
        s_next.fdc = link.wdata[ahs_pkg::FDC_W-1:0];
        if (link.wdata[ahs_pkg::FDC_RESET]) begin
          s_next.state = ahs_pkg::DEV_RESET;
          s_next.dh_rst = 1'b1;
        end
      end else if (!link.alt_sel && link.addr == ahs_pkg::ADDR_STATUS_CMD && can_cmd) begin
        // Command accepted when idle or mid-transfer
        s_next.err = 1'b0;
        s_next.corr = 1'b0;
        s_next.state = ahs_pkg::DEV_EXEC;
        s_next.cmd = link.wdata;
        s_next.cmd_stb = 1'b1;
        s_next.abort_stb = (s_reg.state == ahs_pkg::DEV_XFER);
        s_next.dh_rst = (link.wdata == DIAG_CMD);
      end
      // Commands while busy are ignored
    end
    // Local controller events; sets win over host clears
    case (s_reg.state)
      ahs_pkg::DEV_EXEC: begin
        if (i_cmd_done) begin
          s_next.state = ahs_pkg::DEV_IDLE;
        end else if (i_xfer_start) begin
          s_next.state = ahs_pkg::DEV_XFER;
        end
      end
      ahs_pkg::DEV_XFER: begin
        if (i_xfer_end && s_next.state == ahs_pkg::DEV_XFER) begin
          s_next.state = ahs_pkg::DEV_EXEC;
        end
      end
      ahs_pkg::DEV_RESET: begin
        if (i_cmd_done && !s_reg.fdc[ahs_pkg::FDC_RESET]) begin
          s_next.state = ahs_pkg::DEV_IDLE;
        end
      end
      default: begin
      end
    endcase
    // Completion reporting
    if (i_cmd_done && s_reg.state != ahs_pkg::DEV_IDLE) begin
      if (i_cmd_error) begin
        s_next.err = 1'b1;
        s_next.err_code = i_error_code;
      end
      if (!s_reg.fdc[ahs_pkg::FDC_HOST_IRQ_ENABLE_N_N]) begin
        s_next.irq = 1'b1;
      end
    end
    if (i_corrected_flag) begin
      s_next.corr = 1'b1;
    end
    // Held soft reset keeps the controller busy
    if (s_reg.fdc[ahs_pkg::FDC_RESET]) begin
      s_next.state = ahs_pkg::DEV_RESET;
      s_next.dh_rst = 1'b1;
    end
    // Hard resets
    if (any_rst) begin
      s_next.state = ahs_pkg::DEV_RESET;
      s_next.fdc = ahs_pkg::FDC_RST_VAL;
      s_next.err = 1'b0;
      s_next.corr = 1'b0;
      s_next.irq = 1'b0;
      s_next.cmd_stb = 1'b0;
      s_next.abort_stb = 1'b0;
      s_next.dh_rst = 1'b1;
      s_next.rvalid = 1'b0;
      s_next.rdata = ahs_pkg::BYTE_ZERO;
      s_next.rdata_oe = ahs_pkg::OE_NONE;
    end
    // Loopback low bits follow drive/head reset; write gate untouched
    if (s_next.dh_rst) begin
      s_next.din[ahs_pkg::DIN_WRITE_GATE_N-1:0] = ahs_pkg::DIN_RST_VAL;
    end
    // DMA gate needs both internal enables
    s_next.dma_gate = s_next.fdc[ahs_pkg::FDC_DMA] & i_dma_mode & i_dma_ctl_enable;
    // Busy pin comes from its own flop
    s_next.busy = (s_next.state == ahs_pkg::DEV_EXEC) || (s_next.state == ahs_pkg::DEV_RESET);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_sys_clk) begin
    s_reg <= s_next;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flops
  assign link.rdata = s_reg.rdata;
  assign link.rdata_oe = s_reg.rdata_oe;
  assign link.rvalid = s_reg.rvalid;
  assign link.irq = s_reg.irq;
  assign link.dma_gate = s_reg.dma_gate;
  assign o_cmd_strobe = s_reg.cmd_stb;
  assign o_cmd_code = s_reg.cmd;
  assign o_abort_xfer = s_reg.abort_stb;
  assign o_drive_head_reset = s_reg.dh_rst;
  assign o_error_code = s_reg.err_code;
  assign o_head3_select_enable = s_reg.fdc[ahs_pkg::FDC_HD3];
  assign o_busy = s_reg.busy;

endmodule
`default_nettype wire

// [rtl/ahs_host_end.sv]
`timescale 1ns/10ps
`default_nettype none
module ahs_host_end (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  ahs_link_if.host link,
  input wire logic [3:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [3:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready
);

  ////////////////////////////////////////////////////////////////////////////////
  // State record
  typedef struct packed {
    ahs_pkg::ahs_hst_state_t state; // Link access sequencing
    logic aw_held;                  // Write address taken
    logic [3:0] aw_addr;            // Held write address
    logic w_held;                   // Write data taken
    logic [31:0] w_data;            // Held write data
    logic [3:0] w_strb;             // Held strobes
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [15:0] access;            // Last access request
    logic [7:0] rbyte;              // Last byte read
    logic [7:0] roe;                // Its drive mask
    logic refused;                  // Last request refused
    logic busy_sh;                  // Last seen busy
    logic transfer_request_flag_sh;                  // Last seen transfer request
    logic rst_pin;                  // Host reset pin level
    logic rd;
    logic wr;
    logic alt;
    logic [2:0] addr;
    logic [7:0] wbyte;
  } ahs_hst_st_t;

  ahs_hst_st_t s_reg;
  ahs_hst_st_t s_next;

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic go;
    logic is_status;
    logic is_alt;
    logic blocked;
    go = 1'b0;
    is_status = 1'b0;
    is_alt = 1'b0;
    blocked = 1'b0;
    s_next = s_reg;
    s_next.rd = 1'b0;
    s_next.wr = 1'b0;
    // Link read completion updates busy view
    if (s_reg.state == ahs_pkg::HST_WAIT && link.rvalid) begin
      s_next.state = ahs_pkg::HST_IDLE;
      s_next.rbyte = link.rdata & link.rdata_oe;
      s_next.roe = link.rdata_oe;
      // Only status and mirror reads carry busy; loopback shares address 7
      if ((!s_reg.alt && s_reg.addr == ahs_pkg::ADDR_STATUS_CMD) || (s_reg.alt && s_reg.addr ==
          ahs_pkg::ADDR_ALT_FDC)) begin
        s_next.busy_sh = link.rdata[ahs_pkg::ST_BUSY];
        s_next.transfer_request_flag_sh = link.rdata[ahs_pkg::ST_TRANSFER_REQUEST_FLAG];
      end
    end
    // AXI write channels
    if (i_awvalid && s_reg.awready) begin
      s_next.aw_held = 1'b1;
      s_next.aw_addr = i_awaddr;
    end
    if (i_wvalid && s_reg.wready) begin
      s_next.w_held = 1'b1;
      s_next.w_data = i_wdata;
      s_next.w_strb = i_wstrb;
    end
    if (s_reg.bvalid && i_bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.aw_held && s_reg.w_held && !s_reg.bvalid) begin
      s_next.aw_held = 1'b0;
      s_next.w_held = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = ahs_pkg::RESP_OKAY;
      case (s_reg.aw_addr)
        ahs_pkg::OFS_ACCESS: begin
          go = (s_reg.state == ahs_pkg::HST_IDLE) && (&s_reg.w_strb[1:0]);
        end
        ahs_pkg::OFS_PINCTL: begin
          if (s_reg.w_strb[0]) begin
            s_next.rst_pin = s_reg.w_data[0];
            s_next.busy_sh = s_next.busy_sh | s_reg.w_data[0];
          end
        end
        ahs_pkg::OFS_RESULT: begin
        end
        default: begin
          s_next.bresp = ahs_pkg::RESP_SLVERR;
        end
      endcase
    end
    // Start a link access if allowed
    if (go) begin
      s_next.access = s_reg.w_data[15:0];
      is_alt = s_reg.w_data[ahs_pkg::ACC_ALT];
      is_status = !is_alt && s_reg.w_data[ahs_pkg::ACC_ADDR_LSB +: 3] ==
                  ahs_pkg::ADDR_STATUS_CMD && !s_reg.w_data[ahs_pkg::ACC_WRITE];
      // Only status, mirror, control, loopback while busy
      // New command only once idle or mid-transfer
      blocked = s_reg.busy_sh && !s_reg.transfer_request_flag_sh && !is_alt && !is_status;
      s_next.refused = blocked;
      if (!blocked) begin
        s_next.alt = is_alt;
        s_next.addr = s_reg.w_data[ahs_pkg::ACC_ADDR_LSB +: 3];
        s_next.wbyte = s_reg.w_data[ahs_pkg::ACC_DATA_LSB +: 8];
        if (s_reg.w_data[ahs_pkg::ACC_WRITE]) begin
          s_next.wr = 1'b1;
          if (!is_alt && s_next.addr == ahs_pkg::ADDR_STATUS_CMD) begin
            s_next.busy_sh = 1'b1;
            s_next.transfer_request_flag_sh = 1'b0;
          end
          if (is_alt && s_next.addr == ahs_pkg::ADDR_ALT_FDC &&
              s_next.wbyte[ahs_pkg::FDC_RESET]) begin
            s_next.busy_sh = 1'b1;
          end
        end else begin
          s_next.rd = 1'b1;
          s_next.state = ahs_pkg::HST_WAIT;
        end
      end
    end
    // AXI read channel
    if (s_reg.rvalid && i_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (i_arvalid && s_reg.arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = ahs_pkg::RESP_OKAY;
      s_next.rdata = 32'h0000_0000;
      case (i_araddr)
        ahs_pkg::OFS_ACCESS: s_next.rdata[15:0] = s_reg.access;
        ahs_pkg::OFS_RESULT: begin
          s_next.rdata[7:0] = s_reg.rbyte;
          s_next.rdata[ahs_pkg::RES_OE_LSB +: 8] = s_reg.roe;
          s_next.rdata[ahs_pkg::RES_PEND] = (s_reg.state == ahs_pkg::HST_WAIT);
          s_next.rdata[ahs_pkg::RES_REFUSED] = s_reg.refused;
          s_next.rdata[ahs_pkg::RES_IRQ] = link.irq;
          s_next.rdata[ahs_pkg::RES_DMA] = link.dma_gate;
          s_next.rdata[ahs_pkg::RES_BUSY] = s_reg.busy_sh;
          s_next.rdata[ahs_pkg::RES_TRANSFER_REQUEST_FLAG] = s_reg.transfer_request_flag_sh;
        end
        ahs_pkg::OFS_PINCTL: s_next.rdata[0] = s_reg.rst_pin;
        default: s_next.rresp = ahs_pkg::RESP_SLVERR;
      endcase
    end
    // Ready flags for the next cycle
    s_next.awready = !s_next.aw_held && !s_next.bvalid;
    s_next.wready = !s_next.w_held && !s_next.bvalid;
    s_next.arready = !s_next.rvalid;
    if (i_rst) begin
      s_next = '0;
      s_next.state = ahs_pkg::HST_IDLE;
      s_next.busy_sh = 1'b1;
      s_next.awready = 1'b1;
      s_next.wready = 1'b1;
      s_next.arready = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_sys_clk) begin
    s_reg <= s_next;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign link.host_reset = s_reg.rst_pin;
  assign link.rd = s_reg.rd;
  assign link.wr = s_reg.wr;
  assign link.alt_sel = s_reg.alt;
  assign link.addr = s_reg.addr;
  assign link.wdata = s_reg.wbyte;
  assign o_awready = s_reg.awready;
  assign o_wready = s_reg.wready;
  assign o_bresp = s_reg.bresp;
  assign o_bvalid = s_reg.bvalid;
  assign o_arready = s_reg.arready;
  assign o_rdata = s_reg.rdata;
  assign o_rresp = s_reg.rresp;
  assign o_rvalid = s_reg.rvalid;

endmodule
`default_nettype wire

// [verif/ahs_link_props.sv]
`timescale 1ns/10ps
`default_nettype none
module ahs_link_props (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic host_reset,
  input wire logic rd,
  input wire logic wr,
  input wire logic alt_sel,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic [7:0] rdata_oe,
  input wire logic rvalid,
  input wire logic irq,
  input wire logic dma_gate
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst || host_reset);
  // Primary status read strobe
  logic st_rd;
  assign st_rd = rd && !alt_sel && addr == 3'h7;
  read_answer_a: assert property (rd |=> rvalid)
    else $error("read not answered");
  answer_cause_a: assert property (rvalid |-> $past(rd))
    else $error("answer without read");
  busy_masks_a: assert property (st_rd |=> !rdata[7] || rdata[6:0] == 7'h00)
    else $error("bits shown while busy");
  index_gated_a: assert property (st_rd |=> rdata[7] || rdata[6] || !rdata[1])
    else $error("index shown without ready");
  mirror_keep_a: assert property (rd && alt_sel && addr == 3'h6 && irq |=> irq)
    else $error("mirror read dropped interrupt");
  loop_drive_a: assert property (rd && alt_sel && addr == 3'h7 |=> rdata_oe == 8'h7f)
    else $error("loopback drive mask wrong");
  reset_quiet_a: assert property (disable iff (i_rst)
    host_reset ##1 host_reset |-> !irq && !dma_gate) else $error("outputs live in reset");
  dma_off_a: assert property (wr && alt_sel && addr == 3'h6 && !wdata[0] |=> ##1 !dma_gate)
    else $error("dma gate left on");
  // Main scenarios reached
  cover property (st_rd ##1 rdata[7]);
  cover property (wr && !alt_sel && addr == 3'h7);
  cover property (rd && alt_sel && addr == 3'h7);
endmodule
`default_nettype wire

// [verif/at_host_status_control_regs_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module at_host_status_control_regs_bench;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  // Ready, index, seek done, write fault
  logic [3:0] pin = 4'h0;
  logic err = 1'b0, done = 1'b0, corr = 1'b0, xs = 1'b0;
  logic [1:0] dma = 2'h0;
  logic [6:0] cab = 7'h7f;
  // Bus master side
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
  logic [31:0] wd = 32'h0;
  logic awr, wr_r, bv, arr, rv;
  logic [1:0] rresp;
  logic [31:0] rdat;
  logic [7:0] ccode, ecode;
  logic hd3, busy;
  logic [65:0] q[$];
  logic [65:0] e;
  int bad_count = 0, check_count = 0;
  ahs_link_if link ();
  ahs_device_end ahs_device_end_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .link(link.dev),
    .i_local_reset_pin(1'b0), .i_drive_ready(pin[3]), .i_drive_index(pin[2]),
    .i_seek_done_flag(pin[1]), .i_drive_write_fault(pin[0]), .i_write_gate_n(cab[6]),
    .i_head3_or_reduced_current_n(cab[5]), .i_head_sel2_n(cab[4]), .i_head_sel1_n(cab[3]),
    .i_head_sel0_n(cab[2]), .i_drive_sel1_n(cab[1]), .i_drive_sel0_n(cab[0]),
    .i_cmd_done(done), .i_cmd_error(err), .i_error_code({1'b0, cab}), .i_corrected_flag(corr),
    .i_xfer_start(xs), .i_xfer_end(1'b0), .i_dma_mode(dma[1]), .i_dma_ctl_enable(dma[0]),
    .o_cmd_strobe(), .o_cmd_code(ccode), .o_abort_xfer(), .o_drive_head_reset(),
    .o_error_code(ecode), .o_head3_select_enable(hd3), .o_busy(busy));
  ahs_host_end ahs_host_end_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .link(link.host),
    .i_awaddr(awaddr), .i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hf),
    .i_wvalid(wv), .o_wready(wr_r), .o_bresp(), .o_bvalid(bv), .i_bready(brdy),
    .i_araddr(araddr), .i_arvalid(arv), .o_arready(arr), .o_rdata(rdat), .o_rresp(rresp),
    .o_rvalid(rv), .i_rready(rrdy));
  ahs_link_props ahs_link_props_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .host_reset(link.host_reset), .rd(link.rd), .wr(link.wr), .alt_sel(link.alt_sel),
    .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .rdata_oe(link.rdata_oe),
    .rvalid(link.rvalid), .irq(link.irq), .dma_gate(link.dma_gate));
  initial forever #50 i_sys_clk = ~i_sys_clk;
  // Bus write, held until each channel is taken
  task automatic wr32(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    awaddr <= a;
    wd <= d;
    {awv, wv, brdy} <= 3'h7;
    do begin
      @(posedge i_sys_clk);
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
      if (bv) brdy <= 1'b0;
    end while (!bv);
  endtask
  // Bus read; expectation noted first
  task automatic rd32(input logic [3:0] a, input logic [31:0] x, input logic [31:0] m,
      input logic [1:0] r);
    @(posedge i_sys_clk);
    q.push_back({r, m, x});
    araddr <= a;
    {arv, rrdy} <= 2'h3;
    do begin
      @(posedge i_sys_clk);
      if (arr) arv <= 1'b0;
      if (rv) rrdy <= 1'b0;
    end while (!rv);
  endtask
  // Link access: s is write, alt, addr
  task automatic lk(input logic [4:0] s, input logic [7:0] b);
    wr32(4'h0, {16'h0, b, 3'h0, s});
    repeat (3) @(posedge i_sys_clk);
  endtask
  // Link read, then result byte and drive mask
  task automatic rs(input logic [4:0] s, input logic [7:0] x, input logic [7:0] o);
    lk(s, 8'h00);
    rd32(4'h4, {16'h0, o, x}, 32'h1ffff, 2'h0);
  endtask
  // Pulse done, corrected, transfer start; error level
  task automatic ev(input logic [3:0] v);
    @(posedge i_sys_clk);
    {err, done, corr, xs} <= v;
    @(posedge i_sys_clk);
    {done, corr, xs} <= 3'h0;
  endtask
  // Direct check of a settled device level
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] s);
    check_count++;
    if (s !== x) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", n, x, s);
    end
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Compare each read answer with the oldest note
  always @(posedge i_sys_clk) begin
    if (rv && rrdy) begin
      e = q.pop_front();
      check_count++;
      if ({rresp, rdat & e[63:32]} !== {e[65:64], e[31:0]}) begin
        bad_count++;
        $display("unexpected read: expected %h seen %h", e[31:0], rdat & e[63:32]);
      end
    end
  end
  initial begin
    void'($urandom(32'h1fa4));
    repeat (12) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    rs(5'h07, 8'h80, 8'hff);
    pin <= 4'he;
    ev(4'hc);
    rs(5'h0e, 8'h53, 8'hff);
    chk("error code", 8'h7f, ecode);
    rd32(4'h4, 32'h40000, 32'h40000, 2'h0);
    rs(5'h07, 8'h53, 8'hff);
    rd32(4'h4, 32'h0, 32'h40000, 2'h0);
    pin <= 4'h7;
    rs(5'h07, 8'h31, 8'hff);
    pin <= 4'he;
    repeat (3) begin
      cab <= 7'($urandom);
      @(posedge i_sys_clk);
      rs(5'h0f, {1'b0, cab}, 8'h7f);
    end
    lk(5'h17, 8'($urandom));
    rs(5'h07, 8'h80, 8'hff);
    chk("busy", 8'h01, {7'h0, busy});
    lk(5'h01, 8'h00);
    rd32(4'h4, 32'h20000, 32'h20000, 2'h0);
    ev(4'h6);
    rs(5'h07, 8'h56, 8'hff);
    lk(5'h17, 8'h20);
    ev(4'h1);
    rs(5'h07, 8'h5a, 8'hff);
    lk(5'h17, 8'h21);
    rs(5'h07, 8'h80, 8'hff);
    chk("command code", 8'h21, ccode);
    ev(4'h4);
    rs(5'h07, 8'h52, 8'hff);
    lk(5'h1e, 8'h04);
    rs(5'h0f, {1'b0, cab[6], 6'h3f}, 8'h7f);
    dma <= 2'h3;
    lk(5'h1e, 8'h0b);
    ev(4'h4);
    rs(5'h0e, 8'h52, 8'hff);
    chk("head3 enable", 8'h01, {7'h0, hd3});
    rd32(4'h4, 32'h80000, 32'hc0000, 2'h0);
    dma <= 2'h1;
    rd32(4'h4, 32'h0, 32'h80000, 2'h0);
    dma <= 2'h3;
    wr32(4'h8, 32'h1);
    wr32(4'h8, 32'h0);
    rd32(4'h4, 32'h100000, 32'h180000, 2'h0);
    chk("head3 enable", 8'h00, {7'h0, hd3});
    rd32(4'hc, 32'h0, 32'h0, 2'h2);
    end_of_test();
  end
  // Hang guard
  initial begin
    #500000;
    bad_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
